// >>> logic/lgd_core.sv
// Purpose: self-test, fault display, bus status LED and diagnostic bits of a light grid receiver
// Assumes: rst is the power-on reset; bus chip signals share core_clk
// Notes:   registers over AXI4-Lite, one write and one read at a time
// Behaviour
// - after power-up with field enabled, self-test runs; faults show their code
// - each shown fault code is followed by a one-second pause
// - supply fault code shown three times running forces an internal reset
// - latched errors clear by cause removal plus power cycle; supply also by internal reset
// - every tenth display shows the three-digit system error code instead
// - five fault classes have distinct codes; system error persists over restart
// - configuration fault also clears by save or clear command
// - bus LED green on traffic, red idle or address zero, alternating on fault
// - write-parameter value F returns diagnostic bits in the reflected answer
// - diag bit one is poor beam, bit three internal fault, others zero
// - any internal fault raises the periphery fault flag
// - two-second test, then outputs and LED on only with field clear
`timescale 1ns/1ns
module lgd_core
  import lgd_pkg::*;
#(
  parameter int unsigned PAUSE_CYCLES = PAUSE_CYC,
  parameter int unsigned TEST_CYCLES  = TEST_CYC,
  parameter int unsigned FLASH_CYCLES = FLASH_CYC
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // axi4-lite slave
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // pins
  input  wire logic [4:0]  fault_pin,
  input  wire logic        field_clear_pin,
  input  wire logic        beam_poor_pin,
  input  wire logic        bus_traffic_pin,
  // bus chip side
  input  wire logic [4:0]  slave_addr,
  input  wire logic [11:0] sys_error_detail,
  input  wire logic        param_wr_valid,
  input  wire logic [3:0]  param_wr_value,
  output logic             param_reply_valid,
  output logic [3:0]       param_reply,
  output logic             periphery_fault_flag,
  // indicators and outputs
  output logic [11:0]      disp_code,
  output logic             disp_three_digit,
  output logic             disp_blank,
  output logic             bus_led_green,
  output logic             bus_led_red,
  output logic             outputs_on_led,
  output logic             safety_switching_output_a,
  output logic             safety_switching_output_b,
  output logic             irq
);

  typedef struct packed {
    lgd_phase_t           phase;
    logic [31:0]          timer;
    logic [NUM_CLASS-1:0] latched;
    logic [2:0]           cls;
    logic [3:0]           disp_count;
    logic [1:0]           supply_rep;
    lgd_disp_t            disp;
    logic                 out_on;
    logic                 perif;
    logic [31:0]          flash_cnt;
    logic                 flash_ph;
    logic                 led_g;
    logic                 led_r;
    logic                 reply_valid;
    logic [3:0]           reply;
    logic                 field_en;
    logic [3:0]           irq_status;
    logic [3:0]           irq_mask;
    logic                 aw_got;
    logic [7:0]           aw_addr;
    logic                 w_got;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
  } lgd_state_t;

  lgd_state_t st;
  lgd_state_t next_st;
  lgd_pins_t  pins;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchroniser

  lgd_sync #(
    .W ($bits(lgd_pins_t))
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        ({field_clear_pin, beam_poor_pin, bus_traffic_pin, fault_pin}),
    .q        (pins)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [11:0] class_code(input logic [2:0] c);
    logic [11:0] r;
    r = CODE_SYSTEM;
    unique case (c)
      3'(CLS_SUPPLY): r = CODE_SUPPLY;
      3'(CLS_OUTPUT): r = CODE_OUTPUT;
      3'(CLS_BLANK):  r = CODE_BLANK;
      3'(CLS_CONFIG): r = CODE_CONFIG;
      default:        r = CODE_SYSTEM;
    endcase
    return r;
  endfunction

  // next latched class after cur, wrapping round
  function automatic logic [2:0] next_class(input logic [NUM_CLASS-1:0] lat,
                                            input logic [2:0]           cur);
    logic [2:0] r;
    logic       found;
    int         k;
    r     = cur;
    found = 1'b0;
    for (int i = 1; i <= NUM_CLASS; i++) begin
      k = (int'(cur) + i) % NUM_CLASS;
      if (!found && lat[k]) begin
        r     = 3'(k);
        found = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic hit(input logic [31:0] t, input int unsigned lim);
    return (t >= 32'(lim) - 32'h1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [3:0]  ev;
    logic        wr_do;
    logic [31:0] rd;
    logic        rd_ok;
    logic        wr_ok;
    logic        save_or_clear;
    logic        enter_show;
    ev            = 4'h0;
    wr_do         = 1'b0;
    rd            = 32'h0;
    rd_ok         = 1'b1;
    wr_ok         = 1'b1;
    save_or_clear = 1'b0;
    enter_show    = 1'b0;
    next_st       = st;
    next_st.reply_valid = 1'b0;

    // axi write channel capture, either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_got  = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    wr_do = st.aw_got && st.w_got && !st.bvalid;
    if (wr_do) begin
      unique case (st.aw_addr)
        OFS_CTRL: begin
          if (st.w_strb[0]) begin
            next_st.field_en = st.w_data[CTRL_FIELD_EN];
            save_or_clear    = st.w_data[CTRL_SAVE] | st.w_data[CTRL_CLEAR];
          end
        end
        OFS_IRQ_MASK: begin
          if (st.w_strb[0]) begin
            next_st.irq_mask = st.w_data[3:0];
          end
        end
        OFS_STATUS, OFS_IRQ_STATUS, OFS_DISPLAY, OFS_DIAG: begin
          wr_ok = 1'b1;
        end
        default: wr_ok = 1'b0;
      endcase
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // axi read
    if (s_axi_arvalid && s_axi_arready) begin
      unique case (s_axi_araddr)
        OFS_CTRL:       rd = {31'h0, st.field_en};
        OFS_STATUS:     rd = {22'h0, st.out_on, st.perif, st.latched, st.phase};
        OFS_IRQ_STATUS: begin
          rd                 = {28'h0, st.irq_status};
          next_st.irq_status = 4'h0;
        end
        OFS_IRQ_MASK:   rd = {28'h0, st.irq_mask};
        OFS_DISPLAY:    rd = {18'h0, st.disp.three_digit, st.disp.blank, st.disp.code};
        OFS_DIAG:       rd = {28'h0, st.perif, 1'b0, pins.beam_poor, 1'b0};
        default: begin
          rd    = 32'h0;
          rd_ok = 1'b0;
        end
      endcase
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd;
      next_st.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    // fault latching; only a power cycle clears these, save or clear for config, internal reset for supply
    if (save_or_clear && st.latched[CLS_CONFIG]) begin
      next_st.latched[CLS_CONFIG] = 1'b0;
      ev[IRQ_CFGCLR]              = 1'b1;
    end
    if (st.phase != PH_IDLE) begin
      next_st.latched = next_st.latched | pins.fault;
      if ((pins.fault & ~st.latched) != '0) begin
        ev[IRQ_FAULT] = 1'b1;
      end
    end

    // display and test sequencing
    next_st.timer = st.timer + 32'h1;
    unique case (st.phase)
      PH_IDLE: begin
        next_st.timer = 32'h0;
        if (st.field_en) begin
          next_st.phase = PH_TEST;
        end
      end
      PH_TEST: begin
        if (hit(st.timer, TEST_CYCLES)) begin
          ev[IRQ_TESTDONE] = 1'b1;
          next_st.cls      = 3'(NUM_CLASS - 1);
          if (st.latched != '0) begin
            enter_show = 1'b1;
          end else begin
            next_st.phase = PH_RUN;
          end
        end
      end
      PH_RUN: begin
        if (st.latched != '0) begin
          enter_show = 1'b1;
        end
      end
      PH_SHOW: begin
        if (hit(st.timer, PAUSE_CYCLES)) begin
          next_st.phase      = PH_PAUSE;
          next_st.timer      = 32'h0;
          next_st.disp.blank = 1'b1;
        end
      end
      PH_PAUSE: begin
        if (hit(st.timer, PAUSE_CYCLES)) begin
          if (st.supply_rep == SUPPLY_RESET_CNT) begin
            // internal reset: supply latch reloaded from its synchronised pin, so it stays set if still present
            next_st.phase               = PH_TEST;
            next_st.timer               = 32'h0;
            next_st.supply_rep          = 2'h0;
            next_st.latched[CLS_SUPPLY] = pins.fault[CLS_SUPPLY];
            ev[IRQ_INTRST]              = 1'b1;
          end else if (next_st.latched != '0) begin
            enter_show = 1'b1;
          end else begin
            next_st.phase = PH_RUN;
          end
        end
      end
      default: next_st.phase = PH_IDLE;
    endcase

    if (enter_show) begin
      next_st.phase       = PH_SHOW;
      next_st.timer       = 32'h0;
      next_st.disp.blank  = 1'b0;
      if (st.disp_count == DISPLAY_EVERY) begin
        next_st.disp_count       = 4'h0;
        next_st.disp.code        = sys_error_detail;
        next_st.disp.three_digit = 1'b1;
      end else begin
        next_st.disp_count       = st.disp_count + 4'h1;
        next_st.cls              = next_class(next_st.latched, st.cls);
        next_st.disp.code        = class_code(next_st.cls);
        next_st.disp.three_digit = 1'b0;
        if (next_st.cls == 3'(CLS_SUPPLY)) begin
          next_st.supply_rep = st.supply_rep + 2'h1;
        end else begin
          next_st.supply_rep = 2'h0;
        end
      end
    end else if (next_st.phase == PH_RUN || next_st.phase == PH_IDLE) begin
      next_st.disp.blank = 1'b1;
    end

    // outputs are only enabled in run with a clear field and nothing latched
    next_st.out_on = (next_st.phase == PH_RUN) && pins.field_clear
                     && (next_st.latched == '0);
    next_st.perif  = (next_st.latched != '0);

    // bus status led, fault flashing has priority
    if (hit(st.flash_cnt, FLASH_CYCLES)) begin
      next_st.flash_cnt = 32'h0;
      next_st.flash_ph  = ~st.flash_ph;
    end else begin
      next_st.flash_cnt = st.flash_cnt + 32'h1;
    end
    if (st.perif) begin
      next_st.led_g = st.flash_ph;
      next_st.led_r = ~st.flash_ph;
    end else if (pins.bus_traffic && slave_addr != 5'h00) begin
      next_st.led_g = 1'b1;
      next_st.led_r = 1'b0;
    end else begin
      next_st.led_g = 1'b0;
      next_st.led_r = 1'b1;
    end

    // reflected parameter answer
    if (param_wr_valid) begin
      next_st.reply_valid = 1'b1;
      if (param_wr_value == DIAG_READ_CMD) begin
        next_st.reply = {st.perif, 1'b0, pins.beam_poor, 1'b0};
      end else begin
        next_st.reply = param_wr_value;
      end
    end

    // set wins over the read clear above
    next_st.irq_status = next_st.irq_status | ev;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st       <= '0;
      st.phase <= PH_IDLE;
      st.disp  <= '{three_digit: 1'b0, blank: 1'b1, code: 12'h000};
      st.led_r <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign s_axi_awready             = !st.aw_got && !st.bvalid;
  assign s_axi_wready              = !st.w_got && !st.bvalid;
  assign s_axi_bvalid              = st.bvalid;
  assign s_axi_bresp               = st.bresp;
  assign s_axi_arready             = !st.rvalid;
  assign s_axi_rvalid              = st.rvalid;
  assign s_axi_rdata               = st.rdata;
  assign s_axi_rresp               = st.rresp;
  assign param_reply_valid         = st.reply_valid;
  assign param_reply               = st.reply;
  assign periphery_fault_flag      = st.perif;
  assign disp_code                 = st.disp.code;
  assign disp_three_digit          = st.disp.three_digit;
  assign disp_blank                = st.disp.blank;
  assign bus_led_green             = st.led_g;
  assign bus_led_red               = st.led_r;
  assign outputs_on_led            = st.out_on;
  assign safety_switching_output_a = st.out_on;
  assign safety_switching_output_b = st.out_on;
  assign irq                       = |(st.irq_status & st.irq_mask);

endmodule

// >>> logic/lgd_pkg.sv
// Purpose: shared constants and carrier types of the light grid fault diagnostics
// Assumes: core_clk at 100 MHz
// Notes:   code values other than supply and system are free choices
package lgd_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PAUSE_MS      = 1000;
  localparam int unsigned TEST_MS       = 2000;
  localparam int unsigned FLASH_MS      = 500;
  localparam int unsigned PAUSE_CYC     = PAUSE_MS * (1000000 / CLK_PERIOD_NS);
  localparam int unsigned TEST_CYC      = TEST_MS * (1000000 / CLK_PERIOD_NS);
  localparam int unsigned FLASH_CYC     = FLASH_MS * (1000000 / CLK_PERIOD_NS);

  // register byte offsets
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h0C;
  localparam logic [7:0] OFS_DISPLAY    = 8'h10;
  localparam logic [7:0] OFS_DIAG       = 8'h14;

  // control bits
  localparam int CTRL_FIELD_EN = 0;
  localparam int CTRL_SAVE     = 1;
  localparam int CTRL_CLEAR    = 2;

  // fault classes, index into the latched vector
  localparam int NUM_CLASS   = 5;
  localparam int CLS_SUPPLY  = 0;
  localparam int CLS_OUTPUT  = 1;
  localparam int CLS_BLANK   = 2;
  localparam int CLS_CONFIG  = 3;
  localparam int CLS_SYSTEM  = 4;

  localparam logic [11:0] CODE_SUPPLY = 12'h002;
  localparam logic [11:0] CODE_OUTPUT = 12'h003;
  localparam logic [11:0] CODE_BLANK  = 12'h004;
  localparam logic [11:0] CODE_CONFIG = 12'h005;
  localparam logic [11:0] CODE_SYSTEM = 12'h007;

  localparam logic [3:0] DISPLAY_EVERY    = 4'h9;
  localparam logic [1:0] SUPPLY_RESET_CNT = 2'h3;
  localparam logic [3:0] DIAG_READ_CMD    = 4'hF;

  // interrupt event bits
  localparam int IRQ_FAULT    = 0;
  localparam int IRQ_TESTDONE = 1;
  localparam int IRQ_INTRST   = 2;
  localparam int IRQ_CFGCLR   = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_TEST  = 3'b001,
    PH_RUN   = 3'b010,
    PH_SHOW  = 3'b011,
    PH_PAUSE = 3'b100
  } lgd_phase_t;

  // synchronised pin group
  typedef struct packed {
    logic                 field_clear;
    logic                 beam_poor;
    logic                 bus_traffic;
    logic [NUM_CLASS-1:0] fault;
  } lgd_pins_t;

  typedef struct packed {
    logic        three_digit;
    logic        blank;
    logic [11:0] code;
  } lgd_disp_t;

endpackage

// >>> logic/lgd_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to core_clk
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ns
module lgd_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.q[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.q;

endmodule

// >>> tb/lgd_core_properties.sv
// Purpose: port-level checks of the fault diagnostics core
// Assumes: one clock, synchronous active-high rst
// Notes:   led hold counter has two cycles of slack for the flash phase
`timescale 1ns/1ns
module lgd_core_properties
  import lgd_pkg::*;
#(
  parameter int unsigned FLASH_CYCLES = FLASH_CYC
) (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // bus chip side
  input wire logic [4:0]  slave_addr,
  input wire logic [11:0] sys_error_detail,
  input wire logic        param_wr_valid,
  input wire logic [3:0]  param_wr_value,
  input wire logic        param_reply_valid,
  input wire logic [3:0]  param_reply,
  input wire logic        periphery_fault_flag,
  // indicators and outputs
  input wire logic [11:0] disp_code,
  input wire logic        disp_three_digit,
  input wire logic        disp_blank,
  input wire logic        bus_led_green,
  input wire logic        bus_led_red,
  input wire logic        outputs_on_led,
  input wire logic        safety_switching_output_a,
  input wire logic        safety_switching_output_b
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // stable cycles of the led while flashing; catches a stuck flasher
  int unsigned hold_cnt;
  logic        prev_green;
  always_ff @(posedge core_clk) begin
    prev_green <= bus_led_green;
    if (rst || !periphery_fault_flag || bus_led_green != prev_green) begin
      hold_cnt <= 0;
    end else begin
      hold_cnt <= hold_cnt + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_outputs_off: assert property (
    periphery_fault_flag |-> !safety_switching_output_a && !safety_switching_output_b)
    else $error("outputs on in fault");
  a_outputs_led: assert property (
    safety_switching_output_a |-> outputs_on_led && safety_switching_output_b)
    else $error("outputs mismatch");
  a_reply_pulse: assert property (
    param_reply_valid == $past(param_wr_valid))
    else $error("late answer");
  a_diag_bits: assert property (
    param_reply_valid && $past(param_wr_value) == DIAG_READ_CMD |->
      param_reply[3] == $past(periphery_fault_flag) && !param_reply[2] && !param_reply[0])
    else $error("diag bits");
  a_led_alternates: assert property (
    periphery_fault_flag |-> hold_cnt <= FLASH_CYCLES + 2 && bus_led_green != bus_led_red)
    else $error("led not flashing");
  a_led_red_idle: assert property (
    $past(slave_addr) == 5'h00 && !$past(periphery_fault_flag) && !periphery_fault_flag
      |-> bus_led_red && !bus_led_green)
    else $error("led not red");
  a_pause_blank: assert property (
    $rose(disp_blank) |-> disp_blank[*8])
    else $error("pause short");
  a_three_digit: assert property (
    disp_three_digit && !disp_blank |-> disp_code == sys_error_detail)
    else $error("bad 3-digit code");
endmodule

// >>> tb/lgd_master_model.sv
// Purpose: field-bus master issuing write-parameter calls
// Assumes: device answers one cycle after the request
// Notes:   value line is inverted once released, never left showing old data
`timescale 1ns/1ns
module lgd_master_model
  import lgd_pkg::*;
(
  // clock
  input  wire logic       core_clk,
  // device answer
  input  wire logic       param_reply_valid,
  input  wire logic [3:0] param_reply,
  // master side
  output logic            param_wr_valid,
  output logic [3:0]      param_wr_value,
  output logic [4:0]      slave_addr,
  output logic            bus_traffic_pin
);
  initial begin
    param_wr_valid = 1'b0;
    param_wr_value = 4'h0;
    slave_addr = 5'h05;
    bus_traffic_pin = 1'b1;
  end
  task automatic set_bus(input logic [4:0] a, input logic t);
    slave_addr <= a;
    bus_traffic_pin <= t;
  endtask
  // gap idles first, so slow masters are covered too
  task automatic write_param(input logic [3:0] v, input int gap,
                             output logic [3:0] r, output logic ok);
    repeat (gap) @(posedge core_clk);
    param_wr_valid <= 1'b1;
    param_wr_value <= v;
    @(posedge core_clk);
    param_wr_valid <= 1'b0;
    param_wr_value <= ~v;
    @(posedge core_clk);
    ok = param_reply_valid;
    r = param_reply;
  endtask
endmodule

// >>> tb/tb_top.sv
// Purpose: self-checking bench of the fault diagnostics core
// Assumes: short counts PAUSE 20, TEST 40, FLASH 8
// Notes:   pins pass a synchroniser, so checks wait a few edges
`timescale 1ns/1ns
module tb_top
  import lgd_pkg::*;
;
  localparam int unsigned PC = 20;
  localparam int unsigned TC = 40;
  localparam int unsigned FC = 8;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [4:0]  fault_pin = 5'h00;
  logic        field_clear_pin = 1'b0, beam_poor_pin = 1'b0;
  logic [11:0] sys_error_detail = 12'h123;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        param_wr_valid, param_reply_valid, periphery_fault_flag, bus_traffic_pin;
  logic [3:0]  param_wr_value, param_reply;
  logic [4:0]  slave_addr;
  logic [11:0] disp_code;
  logic        disp_three_digit, disp_blank, bus_led_green, bus_led_red, outputs_on_led;
  logic        safety_switching_output_a, safety_switching_output_b, irq;
  int          fails = 0;
  int          compares = 0;
  always #5 core_clk = ~core_clk;
  lgd_core #(.PAUSE_CYCLES(PC), .TEST_CYCLES(TC), .FLASH_CYCLES(FC)) u_dut (.*);
  lgd_master_model u_master (.*);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic power_cycle;
    rst <= 1'b1;
    cyc(20);
    rst <= 1'b0;
    cyc(1);
  endtask
  // trailing edge avoids same-step redrive
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wait_show(output logic [11:0] c, output logic t);
    while (!disp_blank) @(posedge core_clk);
    while (disp_blank) @(posedge core_clk);
    c = disp_code;
    t = disp_three_digit;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    chk("blank", disp_blank, 1'b1);
    chk("outputs", {safety_switching_output_a, outputs_on_led}, 2'b00);
    rd(OFS_IRQ_MASK, d, r);
    chk("mask", d, 32'h0);
    rd(8'hFC, d, r);
    chk("rd resp", r, RESP_SLVERR);
    wr(8'hFC, 32'h1, r);
    chk("wr resp", r, RESP_SLVERR);
  endtask
  task automatic t_start;
    logic [31:0] d;
    logic [1:0]  r;
    field_clear_pin <= 1'b1;
    wr(OFS_IRQ_MASK, 32'h2, r);
    wr(OFS_CTRL, 32'h1, r);
    rd(OFS_STATUS, d, r);
    chk("phase", d[2:0], 3'h1);
    chk("test off", safety_switching_output_a, 1'b0);
    cyc(TC + 5);
    chk("outputs on", {safety_switching_output_a, safety_switching_output_b,
        outputs_on_led}, 3'b111);
    chk("irq", irq, 1'b1);
    rd(OFS_IRQ_STATUS, d, r);
    chk("irq status", d[3:0], 4'h2);
    chk("irq clr", irq, 1'b0);
    chk("green", {bus_led_green, bus_led_red}, 2'b10);
    u_master.set_bus(5'h00, 1'b1);
    cyc(3);
    chk("red", {bus_led_green, bus_led_red}, 2'b01);
    u_master.set_bus(5'h05, 1'b1);
  endtask
  task automatic t_param;
    logic [3:0] v;
    logic       ok;
    beam_poor_pin <= 1'b1;
    cyc(6);
    u_master.write_param(DIAG_READ_CMD, 0, v, ok);
    chk("diag", {ok, v}, 5'h12);
    u_master.write_param(4'h5, 3, v, ok);
    chk("echo", {ok, v}, 5'h15);
    beam_poor_pin <= 1'b0;
  endtask
  task automatic t_config;
    logic [31:0] cmd [2] = '{32'h3, 32'h5};
    logic [11:0] c;
    logic [3:0]  v;
    logic [1:0]  r;
    logic        t;
    cyc(6);
    for (int k = 0; k < 2; k++) begin
      fault_pin <= 5'h08;
      cyc(6);
      chk("perif", periphery_fault_flag, 1'b1);
      chk("off", safety_switching_output_a, 1'b0);
      u_master.write_param(DIAG_READ_CMD, 0, v, t);
      chk("diag fault", {t, v}, 5'h18);
      wait_show(c, t);
      chk("cfg code", c, CODE_CONFIG);
      fault_pin <= 5'h00;
      cyc(6);
      chk("held", periphery_fault_flag, 1'b1);
      wr(OFS_CTRL, cmd[k], r);
      cyc(3);
      chk("cfg clr", periphery_fault_flag, 1'b0);
    end
  endtask
  task automatic t_system;
    logic [11:0] c;
    logic [1:0]  r;
    logic        t;
    power_cycle;
    wr(OFS_CTRL, 32'h1, r);
    fault_pin <= 5'h10;
    cyc(6);
    fault_pin <= 5'h00;
    for (int i = 1; i <= 11; i++) begin
      wait_show(c, t);
      chk("3 digit", t, i == 10);
      chk("code", c, (i == 10) ? sys_error_detail : CODE_SYSTEM);
    end
    chk("latched", periphery_fault_flag, 1'b1);
    power_cycle;
    chk("cleared", periphery_fault_flag, 1'b0);
    fault_pin <= 5'h10;
    power_cycle;
    wr(OFS_CTRL, 32'h1, r);
    wait_show(c, t);
    chk("persist", c, CODE_SYSTEM);
    fault_pin <= 5'h00;
    power_cycle;
  endtask
  task automatic t_supply;
    logic [31:0] d;
    logic [11:0] c;
    logic [1:0]  r;
    logic        t;
    wr(OFS_IRQ_MASK, 32'h4, r);
    fault_pin <= 5'h01;
    wr(OFS_CTRL, 32'h1, r);
    for (int i = 0; i < 3; i++) begin
      wait_show(c, t);
      chk("supply", c, CODE_SUPPLY);
    end
    chk("no rst", irq, 1'b0);
    cyc(PC + PC + 2);
    chk("int rst", irq, 1'b1);
    rd(OFS_IRQ_STATUS, d, r);
    chk("int rst bit", d[2], 1'b1);
    rd(OFS_STATUS, d, r);
    chk("retest", d[2:0], 3'h1);
    fault_pin <= 5'h00;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    power_cycle;
    t_reset;
    t_start;
    t_param;
    t_config;
    t_system;
    t_supply;
    report_and_stop;
  end
  // all scenarios take well under two thousand cycles
  initial begin
    cyc(20000);
    fails++;
    report_and_stop;
  end
endmodule
bind lgd_core lgd_core_properties #(.FLASH_CYCLES(FLASH_CYCLES)) u_props (.*);
